// file: hw/reset_strap_clock_ratio_config.v
// Reset strap capture and clock ratio decoder.
// Assumes straps are synchronous to clk, which is the system input clock,
// and that a platform rate tick arrives from the clock generator.
// What this block does
// - The platform ratio has no default and is taken only from the four ratio straps at power up.
// - Codes 0010 to 0110 select a platform multiplier equal to the code value, 2 to 6.
// - Code 0000 selects a platform multiplier of 16.
// - Codes 1000, 1001, 1010 and 1100 select multipliers 8, 9, 10 and 12.
// - Two core straps, high bit first, select core ratios 2:1, 5:2, 3:1 and 7:2 for 00 to 11.
// - The platform clock paces the second-level cache, the DDR data rate and the core complex bus.
// - The memory bus clock runs at half the platform clock.
// - Strap pull-ups are enabled in reset and stay on until the strap capture edge, then turn off.
// - Designated outputs are actively driven during reset, not left floating.
// - A functional output that doubles as a strap samples it in reset and is two-way.
`timescale 1ns/1ps
`include "strap_clock_defines.vh"

module reset_strap_clock_ratio_config #(
   parameter SYS_CLK_KHZ = `SYS_CLK_KHZ,
   parameter PLATFORM_MIN_MHZ = `PLATFORM_MIN_MHZ,
   parameter CORE_MIN_MHZ = `CORE_MIN_MHZ,
   parameter CORE_MAX_MHZ = `CORE_MAX_MHZ
) (
   input wire clk,
   input wire reset_n,
   input wire [3:0] platform_ratio_strap_pins,
   input wire core_ratio_strap_high,
   input wire core_ratio_strap_low,
   input wire pci_width_strap,
   input wire platform_clk_tick,
   input wire dual_cfg_pin_in,
   input wire dual_func_data,
   input wire reset_driven_data,
   output reg strap_pullup_en,
   output reg config_done,
   output reg [4:0] platform_mult,
   output reg platform_ratio_invalid,
   output reg [2:0] core_ratio_x2,
   output reg pci_64bit,
   output reg dual_cfg_strap,
   output reg platform_too_slow,
   output reg core_too_slow,
   output reg core_too_fast,
   output reg l2_clk_en,
   output reg ddr_rate_en,
   output reg ccb_clk_en,
   output reg mem_bus_clk_en,
   output reg mem_bus_clk,
   output reg dual_cfg_pin_out,
   output reg dual_cfg_pin_oe,
   output reg reset_driven_out,
   output reg reset_driven_oe
);

   // ******************************************************
   // Reset release
   // ******************************************************
   reg [1:0] rst_sync_reg;
   wire rst_n_int;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n_int = rst_sync_reg[1];

   // ******************************************************
   // Strap decoding
   // ******************************************************
   reg [4:0] plat_mult_next;
   reg plat_invalid_next;
   reg [2:0] core_x2_next;
   reg [31:0] plat_khz_next;
   reg [31:0] core_khz_x2_next;

   always @* begin
      plat_mult_next = `PLAT_MULT_NONE;
      plat_invalid_next = 1'b0;
      case (platform_ratio_strap_pins)
         `PLAT_CODE_X16: begin
            plat_mult_next = `PLAT_MULT_16;
         end
         `PLAT_CODE_X8: begin
            plat_mult_next = `PLAT_MULT_8;
         end
         `PLAT_CODE_X9: begin
            plat_mult_next = `PLAT_MULT_9;
         end
         `PLAT_CODE_X10: begin
            plat_mult_next = `PLAT_MULT_10;
         end
         `PLAT_CODE_X12: begin
            plat_mult_next = `PLAT_MULT_12;
         end
         `PLAT_CODE_X2: begin
            plat_mult_next = {1'b0, platform_ratio_strap_pins};
         end
         `PLAT_CODE_X3: begin
            plat_mult_next = {1'b0, platform_ratio_strap_pins};
         end
         `PLAT_CODE_X4: begin
            plat_mult_next = {1'b0, platform_ratio_strap_pins};
         end
         `PLAT_CODE_X5: begin
            plat_mult_next = {1'b0, platform_ratio_strap_pins};
         end
         `PLAT_CODE_X6: begin
            plat_mult_next = {1'b0, platform_ratio_strap_pins};
         end
         `PLAT_CODE_RSV1,
         `PLAT_CODE_RSV7,
         `PLAT_CODE_RSVB,
         `PLAT_CODE_RSVD,
         `PLAT_CODE_RSVE,
         `PLAT_CODE_RSVF: begin
            plat_invalid_next = 1'b1;
         end
         default: begin
            plat_invalid_next = 1'b1;
         end
      endcase
   end

   always @* begin
      case ({core_ratio_strap_high, core_ratio_strap_low})
         2'h0: begin
            core_x2_next = `CORE_X2_CODE00;
         end
         2'h1: begin
            core_x2_next = `CORE_X2_CODE01;
         end
         2'h2: begin
            core_x2_next = `CORE_X2_CODE10;
         end
         default: begin
            core_x2_next = `CORE_X2_CODE11;
         end
      endcase
   end

   // ******************************************************
   // Frequency estimate
   // ******************************************************
   // Frequencies in kHz; the core figure is doubled to keep half steps exact.
   always @* begin
      plat_khz_next = SYS_CLK_KHZ * {27'h000_0000, plat_mult_next};
      core_khz_x2_next = plat_khz_next * {29'h0000_0000, core_x2_next};
   end

   // ******************************************************
   // Range checks
   // ******************************************************
   // Limits in kHz; the core limits are doubled to match the core figure.
   localparam [31:0] PLAT_MIN_KHZ = PLATFORM_MIN_MHZ * `KHZ_PER_MHZ;
   localparam [31:0] CORE_MIN_KHZ_X2 = CORE_MIN_MHZ * `KHZ_PER_MHZ_X2;
   localparam [31:0] CORE_MAX_KHZ_X2 = CORE_MAX_MHZ * `KHZ_PER_MHZ_X2;
   reg plat_slow_next;
   reg core_slow_next;
   reg core_fast_next;

   // A missing platform ratio reads as zero, so it also trips both slow flags.
   always @* begin
      plat_slow_next = (plat_khz_next < PLAT_MIN_KHZ);
      core_slow_next = (core_khz_x2_next < CORE_MIN_KHZ_X2);
      core_fast_next = (core_khz_x2_next > CORE_MAX_KHZ_X2);
   end

   // ******************************************************
   // Capture sequencer
   // ******************************************************
   localparam [1:0] ST_RESET = 2'h0;
   localparam [1:0] ST_CAPTURE = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   wire capture_en;
   wire run_next;

   always @* begin
      case (state_reg)
         ST_RESET: begin
            state_next = ST_CAPTURE;
         end
         ST_CAPTURE: begin
            state_next = ST_RUN;
         end
         ST_RUN: begin
            state_next = ST_RUN;
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
   end

   // Straps are sampled on the one edge that leaves the capture state.
   assign capture_en = (state_reg == ST_CAPTURE);
   assign run_next = (state_next == ST_RUN);

   always @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         state_reg <= ST_RESET;
         strap_pullup_en <= 1'b1;
         config_done <= 1'b0;
      end else begin
         state_reg <= state_next;
         // Pull-ups stay on through the capture edge, then drop.
         strap_pullup_en <= !run_next;
         config_done <= run_next;
      end
   end

   // ******************************************************
   // Capture registers
   // ******************************************************
   // Captured values change only on the single capture cycle.
   always @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         platform_mult <= `PLAT_MULT_NONE;
         platform_ratio_invalid <= 1'b0;
         core_ratio_x2 <= `CORE_X2_CODE00;
         pci_64bit <= 1'b0;
         dual_cfg_strap <= 1'b0;
         platform_too_slow <= 1'b0;
         core_too_slow <= 1'b0;
         core_too_fast <= 1'b0;
      end else if (capture_en) begin
         platform_mult <= plat_mult_next;
         platform_ratio_invalid <= plat_invalid_next;
         core_ratio_x2 <= core_x2_next;
         pci_64bit <= ~pci_width_strap;
         dual_cfg_strap <= dual_cfg_pin_in;
         // Range checks report board mistakes; they do not change the ratios.
         platform_too_slow <= plat_slow_next;
         core_too_slow <= core_slow_next;
         core_too_fast <= core_fast_next;
      end
   end

   // ******************************************************
   // Platform clock distribution
   // ******************************************************
   reg mem_phase_reg;
   wire run_tick;

   // No enables leave the block without a valid ratio.
   assign run_tick = platform_clk_tick && config_done && !platform_ratio_invalid;

   always @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         l2_clk_en <= 1'b0;
         ddr_rate_en <= 1'b0;
         ccb_clk_en <= 1'b0;
      end else begin
         l2_clk_en <= run_tick;
         ddr_rate_en <= run_tick;
         ccb_clk_en <= run_tick;
      end
   end

   // ******************************************************
   // Memory bus divider
   // ******************************************************
   // Two platform ticks make one memory bus period; the enable marks every second tick.
   always @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         mem_bus_clk_en <= 1'b0;
         mem_bus_clk <= 1'b0;
         mem_phase_reg <= 1'b0;
      end else begin
         mem_bus_clk_en <= run_tick && mem_phase_reg;
         if (run_tick) begin
            mem_phase_reg <= ~mem_phase_reg;
            mem_bus_clk <= ~mem_bus_clk;
         end
      end
   end

   // ******************************************************
   // Pins shared with reset behaviour
   // ******************************************************
   always @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         dual_cfg_pin_out <= 1'b0;
         dual_cfg_pin_oe <= 1'b0;
         reset_driven_out <= `RESET_DRIVE_LEVEL;
         reset_driven_oe <= 1'b1;
      end else begin
         // The shared pin listens until capture is over, then drives.
         dual_cfg_pin_oe <= run_next;
         dual_cfg_pin_out <= run_next ? dual_func_data : 1'b0;
         reset_driven_oe <= 1'b1;
         reset_driven_out <= run_next ? reset_driven_data : `RESET_DRIVE_LEVEL;
      end
   end

endmodule // reset_strap_clock_ratio_config

// file: hw/strap_clock_defines.vh
// Constants for the reset strap capture and clock ratio decoder.
// Assumes it is included by bare name from the design files only.
`ifndef STRAP_CLOCK_DEFINES_VH
`define STRAP_CLOCK_DEFINES_VH

// Platform ratio strap codes.
`define PLAT_CODE_X16 4'h0
`define PLAT_CODE_X2 4'h2
`define PLAT_CODE_X3 4'h3
`define PLAT_CODE_X4 4'h4
`define PLAT_CODE_X5 4'h5
`define PLAT_CODE_X6 4'h6
`define PLAT_CODE_X8 4'h8
`define PLAT_CODE_X9 4'h9
`define PLAT_CODE_X10 4'hA
`define PLAT_CODE_X12 4'hC
// Reserved platform ratio strap codes.
`define PLAT_CODE_RSV1 4'h1
`define PLAT_CODE_RSV7 4'h7
`define PLAT_CODE_RSVB 4'hB
`define PLAT_CODE_RSVD 4'hD
`define PLAT_CODE_RSVE 4'hE
`define PLAT_CODE_RSVF 4'hF
// Platform multipliers set by constant; only 16 and none do not follow the code value.
`define PLAT_MULT_16 5'h10
`define PLAT_MULT_8 5'h08
`define PLAT_MULT_9 5'h09
`define PLAT_MULT_10 5'h0A
`define PLAT_MULT_12 5'h0C
`define PLAT_MULT_NONE 5'h00

// Core ratio in half steps: 2:1, 5:2, 3:1, 7:2.
`define CORE_X2_CODE00 3'h4
`define CORE_X2_CODE01 3'h5
`define CORE_X2_CODE10 3'h6
`define CORE_X2_CODE11 3'h7

// Frequency limits in MHz.
`define PLATFORM_MIN_MHZ 200
`define CORE_MIN_MHZ 400
`define CORE_MAX_MHZ 1000
// Scale from MHz to kHz, plain and doubled for the half-step core figure.
`define KHZ_PER_MHZ 32'h0000_03E8
`define KHZ_PER_MHZ_X2 32'h0000_07D0
// System input clock rate in kHz (clk at 100 MHz).
`define SYS_CLK_KHZ 100000
// Memory bus runs at platform clock divided by this.
`define MEM_BUS_DIV 2
// Level driven on the reset-driven output while in reset.
`define RESET_DRIVE_LEVEL 1'b0

`endif

// file: sim/reset_strap_clock_ratio_config_test.sv
// Self-checking bench for the strap capture and clock ratio decoder.
// Assumes the board model and the bound checker are compiled first.
`timescale 1ns/1ps
module reset_strap_clock_ratio_config_test;
   reg clk = 1'b0;
   reg reset_n = 1'b0;
   reg [7:0] code = 8'h00;
   integer miscompares = 0;
   integer n_tests = 0;
   wire [3:0] pins;
   wire [4:0] mult;
   wire [2:0] x2;
   wire hi, lo, pci, pin_in, tick, pu, done, inv, p64, dstr, ccb, men, pout, poe, rout, roe;
   wire ps, cs, cf, l2, ddr;
`define CHK(n, e, s) begin n_tests = n_tests + 1; if ((s) !== (e)) begin miscompares = miscompares + 1; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
   always #5 clk = ~clk;
   strap_board board (.clk(clk), .config_done(done), .code(code), .pin_out(pout), .pin_oe(poe), .plat(pins),
      .hi(hi), .lo(lo), .pci(pci), .pin_in(pin_in), .tick(tick));
   reset_strap_clock_ratio_config uut (.clk(clk), .reset_n(reset_n), .platform_ratio_strap_pins(pins),
      .core_ratio_strap_high(hi), .core_ratio_strap_low(lo), .pci_width_strap(pci), .platform_clk_tick(tick),
      .dual_cfg_pin_in(pin_in), .dual_func_data(1'b1), .reset_driven_data(1'b1), .strap_pullup_en(pu),
      .config_done(done), .platform_mult(mult), .platform_ratio_invalid(inv), .core_ratio_x2(x2),
      .pci_64bit(p64), .dual_cfg_strap(dstr), .platform_too_slow(ps), .core_too_slow(cs), .core_too_fast(cf),
      .l2_clk_en(l2), .ddr_rate_en(ddr), .ccb_clk_en(ccb), .mem_bus_clk_en(men), .mem_bus_clk(),
      .dual_cfg_pin_out(pout), .dual_cfg_pin_oe(poe), .reset_driven_out(rout), .reset_driven_oe(roe));
   function [4:0] em(input [3:0] c);
      em = (c == 4'h0) ? 5'h10 : ((c > 4'h1 && c < 4'h7) || c == 4'h8 || c == 4'h9 || c == 4'hA || c == 4'hC) ?
         {1'b0, c} : 5'h00;
   endfunction
   task summarize;
      begin
         if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   task boot(input [7:0] c);
      integer i;
      begin
         @(posedge clk) reset_n <= 1'b0;
         code <= c;
         repeat (6) @(posedge clk);
         `CHK("pullup", 1'b1, pu)
         `CHK("drive_oe", 1'b1, roe)
         `CHK("shared_oe", 1'b0, poe)
         `CHK("drive_out", 1'b0, rout)
         `CHK("shared_out", 1'b0, pout)
         reset_n <= 1'b1;
         for (i = 0; i < 20 && done !== 1'b1; i = i + 1) @(posedge clk);
         repeat (5) @(posedge clk);
         #1;
      end
   endtask
   task t_plat;
      integer c;
      begin
         for (c = 0; c < 16; c = c + 1) begin
            boot({1'b0, c[3:0], 3'h0});
            `CHK("mult", em(c[3:0]), mult)
            `CHK("invalid", em(c[3:0]) == 5'h00, inv)
            `CHK("pullup_off", 1'b0, pu)
            `CHK("shared_oe_on", 1'b1, poe)
            `CHK("shared_out_run", 1'b1, pout)
            `CHK("drive_out_run", 1'b1, rout)
            `CHK("plat_slow", em(c[3:0]) * 100 < 200, ps)
            `CHK("core_slow", em(c[3:0]) * 200 < 400, cs)
            `CHK("core_fast", em(c[3:0]) * 200 > 1000, cf)
         end
      end
   endtask
   task t_core;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1) begin
            boot({k[0], 4'h2, k[1:0], k[0]});
            `CHK("core", {1'b1, k[1:0]}, x2)
            `CHK("pci64", ~k[0], p64)
            `CHK("shared_strap", k[0], dstr)
         end
      end
   endtask
   task t_tick(input [3:0] c, input integer n);
      integer i, nc, nm, nl, nd;
      begin
         boot({1'b0, c, 3'h0});
         nc = 0;
         nm = 0;
         nl = 0;
         nd = 0;
         for (i = 0; i < 2 * n + 40 * (n == 0); i = i + 1) begin
            @(posedge clk);
            #1;
            nc = nc + ccb;
            nm = nm + men;
            nl = nl + l2;
            nd = nd + ddr;
         end
         `CHK("ccb_count", n, nc)
         `CHK("mem_count", n / 2, nm)
         `CHK("l2_count", n, nl)
         `CHK("ddr_count", n, nd)
      end
   endtask
   initial begin
      t_plat;
      t_core;
      t_tick(4'h2, 20);
      t_tick(4'h1, 0);
      summarize;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares = miscompares + 1;
      summarize;
   end
endmodule // reset_strap_clock_ratio_config_test

// file: sim/strap_board.sv
// Board straps and clock generator tick seen by the decoder.
// Assumes code holds shared pin, platform, core and width strap values.
`timescale 1ns/1ps
module strap_board (
   input wire clk,
   input wire config_done,
   input wire [7:0] code,
   input wire pin_out,
   input wire pin_oe,
   output wire [3:0] plat,
   output wire hi,
   output wire lo,
   output wire pci,
   output wire pin_in,
   output reg tick
);
   initial tick = 1'b0;
   // Straps hold the intended value in reset, then flip so late changes can be seen to be ignored.
   assign {plat, hi, lo, pci} = config_done ? ~code[6:0] : code[6:0];
   assign pin_in = pin_oe ? pin_out : code[7];
   always @(posedge clk) begin
      tick <= config_done & ~tick;
   end
endmodule // strap_board

// file: sim/strap_checker.sv
// Concurrent checks on strap capture and platform clock enables.
// Assumes it is bound to the decoder top module and sees its ports only.
`timescale 1ns/1ps
module strap_checker (
   input wire clk,
   input wire reset_n,
   input wire [3:0] platform_ratio_strap_pins,
   input wire core_ratio_strap_high,
   input wire core_ratio_strap_low,
   input wire platform_clk_tick,
   input wire strap_pullup_en,
   input wire config_done,
   input wire [4:0] platform_mult,
   input wire platform_ratio_invalid,
   input wire [2:0] core_ratio_x2,
   input wire ccb_clk_en,
   input wire mem_bus_clk_en,
   input wire mem_bus_clk
);
   reg odd_reg;
   wire run_ok;
   assign run_ok = platform_clk_tick && config_done && !platform_ratio_invalid;
   function [4:0] pm(input [3:0] c);
      pm = (c == 4'h0) ? 5'h10 : ((c > 4'h1 && c < 4'h7) || c == 4'h8 || c == 4'h9 || c == 4'hA || c == 4'hC) ?
         {1'b0, c} : 5'h00;
   endfunction
   // Counts platform enables so every second one can be matched to a memory bus enable.
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) odd_reg <= 1'b0;
      else if (ccb_clk_en) odd_reg <= ~odd_reg;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence cap_s;
      $rose(config_done);
   endsequence
   sequence tick_s;
      platform_clk_tick && config_done && !platform_ratio_invalid;
   endsequence
   pullup_off_a: assert property (config_done |-> !strap_pullup_en)
      else $error("pull-up on after capture");
   plat_capture_a: assert property (cap_s |-> platform_mult == pm($past(platform_ratio_strap_pins)))
      else $error("platform multiplier wrong");
   invalid_flag_a: assert property (config_done |-> platform_ratio_invalid == (platform_mult == 5'h00))
      else $error("invalid flag wrong");
   core_capture_a: assert property (cap_s |-> core_ratio_x2 == {1'b1, $past(core_ratio_strap_high),
      $past(core_ratio_strap_low)})
      else $error("core ratio wrong");
   held_value_a: assert property (config_done && $past(config_done) |-> $stable(platform_mult) &&
      $stable(core_ratio_x2))
      else $error("captured value changed");
   tick_enable_a: assert property (tick_s |=> ccb_clk_en)
      else $error("enable missing after tick");
   enable_cause_a: assert property (ccb_clk_en |-> $past(run_ok))
      else $error("enable without tick");
   mem_toggle_a: assert property ((mem_bus_clk != $past(mem_bus_clk)) == ccb_clk_en)
      else $error("memory clock toggle wrong");
   mem_half_a: assert property (mem_bus_clk_en == (ccb_clk_en && odd_reg))
      else $error("memory enable not every second tick");
endmodule // strap_checker
bind reset_strap_clock_ratio_config strap_checker u_chk (.clk(clk), .reset_n(reset_n),
   .platform_ratio_strap_pins(platform_ratio_strap_pins), .core_ratio_strap_high(core_ratio_strap_high),
   .core_ratio_strap_low(core_ratio_strap_low), .platform_clk_tick(platform_clk_tick),
   .strap_pullup_en(strap_pullup_en), .config_done(config_done), .platform_mult(platform_mult),
   .platform_ratio_invalid(platform_ratio_invalid), .core_ratio_x2(core_ratio_x2), .ccb_clk_en(ccb_clk_en),
   .mem_bus_clk_en(mem_bus_clk_en), .mem_bus_clk(mem_bus_clk));
